// File: hw/siom_pkg.sv
// Package for the secondary I/O supply monitor: register map, fields, timing
package siom_pkg;
	localparam logic [11:0] REG_IRQ_ENABLE = 12'h000;
	localparam logic [11:0] REG_IRQ_FLAGS  = 12'h004;
	localparam logic [11:0] REG_STATE      = 12'h008;
	localparam logic [11:0] REG_IRQ_MASK   = 12'h00c;
	localparam int          ADDR_W         = 12;
	localparam int          FLD_CHANGE     = 0;
	localparam logic [7:0]  RST_IRQ_ENABLE = 8'h00;
	localparam logic [7:0]  RST_IRQ_FLAGS  = 8'h00;
	localparam logic [7:0]  RST_STATE      = 8'h00;
	localparam logic [7:0]  RST_IRQ_MASK   = 8'h01;
	localparam int          PIN_W          = 8;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;
	localparam int          SYNC_STAGES    = 3;
	localparam int          CLK_PERIOD_NS  = 50;
	localparam int          CHG_TO_FLAG_CYC = 4;
	typedef enum logic [1:0] {
		SIOM_W_IDLE = 2'b00,
		SIOM_W_RESP = 2'b01
	} siom_wstate_e;
endpackage

// File: hw/siom_top.sv
// Secondary I/O supply monitor: status, change flag, interrupt, event and pin gating
// Summary of operation
// - Single-supply fuse: status reads one, change flag reads zero.
// - Secondary pins tri-stated when main supply is lost, or secondary supply in dual mode.
// - Supply returning good re-applies current port configuration to pins.
// - Main supply loss tri-states pins only; port configuration is not reset.
// - Peripherals keep running while pins are tri-stated.
// - Level event output follows the supply status bit exactly.
// - Block only generates events; it has no event inputs.
// - Change flag set on every status change in dual mode, either direction, except the jump as dual mode settles.
// - Writing one to flag bit 0 clears it; zero leaves it.
// - Control bit 0 enables change interrupt; resets to zero.
// - Interrupt asserted while enable, mask and flag set, until cleared.
// - Status bit 0 is read-only; writes ignored.
// - Status zero: pins tri-stated; one: pins driven from port registers while main supply is good.
// - Monitoring continues in every sleep mode when fuse enables.
// - No debug freeze; operation continues during debug halt.
`timescale 1ns/1ns
module siom_top
	import siom_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              ARST_N,
	input  wire logic              SUPPLY_CONFIG_FUSE,
	input  wire logic              SECONDARY_SUPPLY_OK,
	input  wire logic              MAIN_SUPPLY_OK,
	input  wire logic [PIN_W-1:0]  PORT_OUT,
	input  wire logic [PIN_W-1:0]  PORT_DIR,
	input  wire logic [PIN_W-1:0]  PIN_IN,
	output logic [PIN_W-1:0]       PIN_OUT,
	output logic [PIN_W-1:0]       PIN_OE,
	output logic [PIN_W-1:0]       PORT_IN,
	output logic                   SECOND_SUPPLY_OK_EVENT,
	output logic                   IRQ,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY
);

	// Register index decode, shared by read and write paths
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		case (a)
			REG_IRQ_ENABLE: reg_sel = 3'h1;
			REG_IRQ_FLAGS:  reg_sel = 3'h2;
			REG_STATE:      reg_sel = 3'h3;
			REG_IRQ_MASK:   reg_sel = 3'h4;
			default:        reg_sel = 3'h0;
		endcase
	endfunction

	logic [SYNC_STAGES-1:0] sync_sup;
	logic [SYNC_STAGES-1:0] sync_main;
	logic                   supply_good;
	logic                   main_good;
	logic                   dual_mode;
	logic                   status_bit;
	logic                   status_prev;
	logic                   change_evt;
	logic                   supply_change_flag;
	logic                   supply_change_irq_enable;
	logic                   irq_mask;
	logic                   flag_read;
	logic                   pins_live;
	logic                   aw_held;
	logic                   w_held;
	logic [ADDR_W-1:0]      aw_addr;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;
	logic                   wr_go;
	logic                   clr_flag;
	siom_wstate_e           wstate;

	// Fuse is a strap, caught like any pin; dual_prev hides the one-off status
	// jump from forced one to the real level when dual mode first settles
	logic [2:0] fuse_sync;
	logic       dual_prev;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fuse_sync <= 3'b000;
			dual_mode <= 1'b0;
			dual_prev <= 1'b0;
		end else begin
			fuse_sync <= {fuse_sync[1:0], SUPPLY_CONFIG_FUSE};
			if (fuse_sync[2] == fuse_sync[1]) begin
				dual_mode <= fuse_sync[2];
			end
			dual_prev <= dual_mode;
		end
	end

	// Three-stage synchronisers; a level counts once stages 1 and 2 agree
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync_sup    <= '0;
			sync_main   <= '0;
			supply_good <= 1'b0;
			main_good   <= 1'b0;
		end else begin
			sync_sup  <= {sync_sup[SYNC_STAGES-2:0], SECONDARY_SUPPLY_OK};
			sync_main <= {sync_main[SYNC_STAGES-2:0], MAIN_SUPPLY_OK};
			if (sync_sup[2] == sync_sup[1]) begin
				supply_good <= sync_sup[2];
			end
			if (sync_main[2] == sync_main[1]) begin
				main_good <= sync_main[2];
			end
		end
	end

	// Single-supply mode forces the status to one
	assign status_bit = dual_mode ? supply_good : 1'b1;

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			status_prev <= 1'b0;
		end else begin
			status_prev <= status_bit;
		end
	end
	assign change_evt = dual_mode && dual_prev && (status_bit != status_prev);

	// Event output is the status bit itself; no event inputs exist
	assign SECOND_SUPPLY_OK_EVENT = status_bit;

	// Sticky change flag; a new change wins over a simultaneous clear
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			supply_change_flag <= 1'b0;
		end else if (change_evt) begin
			supply_change_flag <= 1'b1;
		end else if (clr_flag) begin
			supply_change_flag <= 1'b0;
		end
	end
	assign flag_read = dual_mode & supply_change_flag;

	assign IRQ = supply_change_irq_enable & irq_mask & flag_read;

	// Pins: tri-state on main supply loss, or secondary loss in dual mode; port registers pass through live, so
	// recovery re-applies them without software help. Peripherals are never stalled.
	// Main supply loss only tri-states pins via main_good; nothing is reset, so port setup passes through again on return
	assign pins_live = main_good & status_bit;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PIN_OUT <= '0;
			PIN_OE  <= '0;
			PORT_IN <= '0;
		end else begin
			PIN_OUT <= PORT_OUT;
			PIN_OE  <= pins_live ? PORT_DIR : '0;
			PORT_IN <= pins_live ? PIN_IN : '0;
		end
	end

	// AXI4-Lite write: address and data caught in either order
	assign AWREADY = !aw_held && (wstate == SIOM_W_IDLE);
	assign WREADY  = !w_held && (wstate == SIOM_W_IDLE);
	assign wr_go   = aw_held && w_held && (wstate == SIOM_W_IDLE);

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			wstate  <= SIOM_W_IDLE;
			BVALID  <= 1'b0;
			BRESP   <= RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			case (wstate)
				SIOM_W_IDLE: begin
					if (wr_go) begin
						aw_held <= 1'b0;
						w_held  <= 1'b0;
						BVALID  <= 1'b1;
						BRESP   <= (reg_sel(aw_addr) == 3'h0) ? RESP_SLVERR : RESP_OKAY;
						wstate  <= SIOM_W_RESP;
					end
				end
				SIOM_W_RESP: begin
					if (BREADY) begin
						BVALID <= 1'b0;
						wstate <= SIOM_W_IDLE;
					end
				end
				default: wstate <= SIOM_W_IDLE;
			endcase
		end
	end

	assign clr_flag = wr_go && reg_sel(aw_addr) == 3'h2 && w_strb[0] && w_data[FLD_CHANGE];

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			supply_change_irq_enable <= RST_IRQ_ENABLE[FLD_CHANGE];
			irq_mask                 <= RST_IRQ_MASK[FLD_CHANGE];
		end else if (wr_go && w_strb[0]) begin
			if (reg_sel(aw_addr) == 3'h1) begin
				supply_change_irq_enable <= w_data[FLD_CHANGE];
			end
			if (reg_sel(aw_addr) == 3'h4) begin
				irq_mask <= w_data[FLD_CHANGE];
			end
		end
	end
	// Writes to the status register change nothing

	// AXI4-Lite read: one read at a time, answer one cycle after address
	assign ARREADY = !RVALID;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RVALID <= 1'b0;
			RDATA  <= '0;
			RRESP  <= RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RRESP  <= RESP_OKAY;
			case (reg_sel(ARADDR))
				3'h1:    RDATA <= {31'h0, supply_change_irq_enable};
				3'h2:    RDATA <= {31'h0, flag_read};
				3'h3:    RDATA <= {31'h0, status_bit};
				3'h4:    RDATA <= {31'h0, irq_mask};
				default: begin
					RDATA <= '0;
					RRESP <= RESP_SLVERR;
				end
			endcase
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	sequence change_seen_s;
		change_evt;
	endsequence
	sequence flag_up_s;
		##1 supply_change_flag;
	endsequence

	single_status_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!dual_mode |-> status_bit && !flag_read)
		else $error("single supply status wrong");

	pins_tristate_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!pins_live |=> PIN_OE == '0)
		else $error("pins driven during supply loss");

	pins_reload_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		pins_live |=> PIN_OE == $past(PORT_DIR))
		else $error("port config not reapplied");

	event_follow_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		SECOND_SUPPLY_OK_EVENT == status_bit)
		else $error("event not following status");

	flag_set_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		change_seen_s |-> flag_up_s)
		else $error("change flag not set");

	flag_clear_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		clr_flag && !change_evt |=> !supply_change_flag)
		else $error("flag not cleared");

	flag_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		supply_change_flag && !clr_flag |=> supply_change_flag)
		else $error("flag lost");

	irq_level_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		IRQ == (supply_change_irq_enable && irq_mask && flag_read))
		else $error("irq wrong");

	enable_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		wr_go && w_strb[0] && reg_sel(aw_addr) == 3'h1 |=> supply_change_irq_enable == $past(w_data[0]))
		else $error("enable not written");

	sync_once_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		change_evt |=> !change_evt)
		else $error("double change detect");

	single_irq_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!dual_mode |-> !IRQ)
		else $error("irq in single supply");

	single_event_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!dual_mode |-> SECOND_SUPPLY_OK_EVENT)
		else $error("event low in single supply");

	main_loss_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!main_good |=> PIN_OE == '0)
		else $error("pins driven without main supply");

	input_gate_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!pins_live |=> PORT_IN == '0)
		else $error("pin input passed while tri-stated");

	input_pass_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		pins_live |=> PORT_IN == $past(PIN_IN))
		else $error("pin input not passed");

	output_copy_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		pins_live || !pins_live |=> PIN_OUT == $past(PORT_OUT))
		else $error("pin output value stalled");

	irq_enable_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!supply_change_irq_enable |-> !IRQ)
		else $error("irq without enable");

	irq_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		IRQ && !wr_go |=> IRQ)
		else $error("irq dropped before clear");

	flag_quiet_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!supply_change_flag && !change_evt |=> !supply_change_flag)
		else $error("flag set without change");

	sync_agree_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		supply_good != $past(supply_good) |-> $past(sync_sup[2]) == $past(sync_sup[1]))
		else $error("supply level taken before stages agree");

	status_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		ARVALID && ARREADY && reg_sel(ARADDR) == 3'h3 |=> RDATA == {31'h0, $past(status_bit)})
		else $error("status read wrong");

	read_upper_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RVALID |-> RDATA[31:1] == 31'h0)
		else $error("unused read bits set");

	read_answer_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		ARVALID && ARREADY |=> RVALID)
		else $error("read not answered");

	unmapped_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		ARVALID && ARREADY && reg_sel(ARADDR) == 3'h0 |=> RRESP == RESP_SLVERR)
		else $error("unmapped read not refused");

	write_answer_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		wr_go |=> BVALID)
		else $error("write not answered");

	bresp_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		BVALID && !BREADY |=> BVALID && BRESP == $past(BRESP))
		else $error("write response dropped");

	rdata_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RVALID && !RREADY |=> RVALID && RDATA == $past(RDATA) && RRESP == $past(RRESP))
		else $error("read data dropped");

endmodule

// File: bench/tb_top.sv
// Self-checking testbench for the secondary I/O supply monitor
`timescale 1ns/1ns
module tb_top
	import siom_pkg::*;
;
	logic mclk = 1'b0, arst_n = 1'b0, fuse = 1'b1, sec_ok = 1'b0, main_ok = 1'b1;
	logic [PIN_W-1:0] port_out = '0, port_dir = '0, pin_in = '0, pin_out, pin_oe, port_in;
	logic event_ok, irq, awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
	logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic [1:0] bresp, rresp, r;
	integer seed = 32'h291d;
	int miscompares = 0, total_checks = 0;
	logic cur, v, ef;

	siom_top siom_top_inst (.MCLK(mclk), .ARST_N(arst_n), .SUPPLY_CONFIG_FUSE(fuse), .SECONDARY_SUPPLY_OK(sec_ok),
		.MAIN_SUPPLY_OK(main_ok), .PORT_OUT(port_out), .PORT_DIR(port_dir), .PIN_IN(pin_in), .PIN_OUT(pin_out),
		.PIN_OE(pin_oe), .PORT_IN(port_in), .SECOND_SUPPLY_OK_EVENT(event_ok), .IRQ(irq), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

	always #25 mclk = ~mclk;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic fail(input string m);
		miscompares++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) fail(m);
	endtask

	function automatic logic [PIN_W-1:0] gate(input logic g, input logic [PIN_W-1:0] x);
		return g ? x : '0;
	endfunction

	// Every task starts and ends just after a rising edge; readies are sampled mid-cycle where settled
	task automatic wr(input logic [11:0] a, input logic [31:0] dat);
		int n;
		logic ta, tw, done;
		n = 0;
		done = 1'b0;
		awaddr <= a; wdata <= dat; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!done && n < 50) begin
			@(negedge mclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid && bready;
			r = bresp;
			@(posedge mclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		@(posedge mclk);
		if (!done) begin
			fail("write timeout");
			end_sim();
		end
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		logic ta, done;
		n = 0;
		done = 1'b0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!done && n < 50) begin
			@(negedge mclk);
			ta = arvalid && arready;
			done = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge mclk);
			if (ta) arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		@(posedge mclk);
		if (!done) begin
			fail("read timeout");
			end_sim();
		end
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp, "register read");
	endtask

	// Supply-good is asynchronous, so the wait is bounded rather than a fixed count
	task automatic supply(input logic val);
		int n;
		n = 0;
		sec_ok <= val;
		do begin
			@(negedge mclk);
			n++;
		end while (event_ok !== val && n < 12);
		repeat (2) @(posedge mclk);
		if (event_ok !== val) begin
			fail("status never followed supply");
			end_sim();
		end
	endtask

	task automatic pins(input logic good);
		port_out <= $random(seed); port_dir <= $random(seed); pin_in <= $random(seed);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk(pin_oe, gate(good, port_dir), "pin enable");
		chk(port_in, gate(good, pin_in), "pin input");
		chk(pin_out, port_out, "pin output");
		@(posedge mclk);
	endtask

	task automatic do_reset(input logic f);
		arst_n <= 1'b0; fuse <= f; sec_ok <= 1'b0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask

	initial begin
		do_reset(1'b1);
		rdchk(REG_IRQ_ENABLE, 32'h0);
		rdchk(REG_IRQ_FLAGS, 32'h0);
		rdchk(REG_STATE, 32'h0);
		rdchk(REG_IRQ_MASK, 32'h1);
		rdchk(12'h010, 32'h0);
		chk(r, RESP_SLVERR, "unmapped response");
		pins(1'b0);
		$display("test reset values done");
		wr(REG_IRQ_ENABLE, 32'h1);
		chk(r, RESP_OKAY, "write response");
		rdchk(REG_IRQ_ENABLE, 32'h1);
		supply(1'b1);
		chk(event_ok, 1'b1, "event level");
		rdchk(REG_STATE, 32'h1);
		rdchk(REG_IRQ_FLAGS, 32'h1);
		chk(irq, 1'b1, "irq raised");
		pins(1'b1);
		wr(REG_IRQ_FLAGS, 32'h0);
		rdchk(REG_IRQ_FLAGS, 32'h1);
		chk(irq, 1'b1, "irq held");
		wr(REG_STATE, 32'h0);
		rdchk(REG_STATE, 32'h1);
		wr(REG_IRQ_MASK, 32'h0);
		chk(irq, 1'b0, "irq masked");
		wr(REG_IRQ_MASK, 32'h1);
		wr(REG_IRQ_FLAGS, 32'h1);
		rdchk(REG_IRQ_FLAGS, 32'h0);
		chk(irq, 1'b0, "irq cleared");
		$display("test rise and irq done");
		supply(1'b0);
		chk(event_ok, 1'b0, "event low");
		rdchk(REG_IRQ_FLAGS, 32'h1);
		pins(1'b0);
		wr(REG_IRQ_FLAGS, 32'h1);
		supply(1'b1);
		main_ok <= 1'b0;
		repeat (5) @(posedge mclk);
		pins(1'b0);
		main_ok <= 1'b1;
		repeat (5) @(posedge mclk);
		pins(1'b1);
		$display("test supply loss done");
		wr(REG_IRQ_FLAGS, 32'h1);
		cur = 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			ef = (v != cur);
			supply(v);
			rdchk(REG_IRQ_FLAGS, {31'h0, ef});
			chk(irq, ef, "irq follows flag");
			wr(REG_IRQ_FLAGS, 32'h1);
			cur = v;
		end
		$display("test random toggles done");
		do_reset(1'b0);
		rdchk(REG_STATE, 32'h1);
		sec_ok <= 1'b1;
		repeat (8) @(posedge mclk);
		sec_ok <= 1'b0;
		repeat (8) @(posedge mclk);
		rdchk(REG_IRQ_FLAGS, 32'h0);
		chk(event_ok, 1'b1, "single supply event");
		chk(irq, 1'b0, "single supply irq");
		$display("test single supply done");
		end_sim();
	end
endmodule
